// file: rtl/cuf_regs.svh
`ifndef CUF_REGS_SVH
`define CUF_REGS_SVH

`define CUF_IDX_MIXED 6'h0C
`define CUF_IDX_RXHOLD 6'h0D
`define CUF_IDX_STATUS 6'h0E
`define CUF_IDX_CTRL 6'h10

`define CUF_PEC_HI 6
`define CUF_PEC_LO 4
`define CUF_FL_HI 2
`define CUF_FL_LO 0

`define CUF_CTRL_RUN 0
`define CUF_CTRL_TXMODE 1
`define CUF_CTRL_T1 2
`define CUF_CTRL_LCT 3
`define CUF_CTRL_MASK 4
`define CUF_CTRL_RST 8'h00
`define CUF_FCR_RST 8'h00

`define CUF_CLK_NS 10
`define CUF_CLR_NS 2000
`define CUF_CLR_CYC (`CUF_CLR_NS / `CUF_CLK_NS)
`define CUF_TBE_DLY 3
`define CUF_RETX_HALF 6'h1E
`define CUF_MANUAL_HALF 6'h1B
`define CUF_HALF_MAX 6'h3F

`endif

// file: rtl/cuf_pkg.sv
package cuf_pkg;
    typedef enum logic [1:0] {
        CUF_TX_IDLE,
        CUF_TX_SEND,
        CUF_TX_RETRY,
        CUF_TX_MANUAL
    } cuf_tx_state_t;
    typedef logic [7:0] cuf_byte_t;
endpackage

// file: rtl/cuf_core.sv
`timescale 1ns/10ps
`include "cuf_regs.svh"
module cuf_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic aux_irq_input,
    input wire logic rx_char_valid,
    input wire logic [7:0] rx_char_data,
    input wire logic rx_parity_bad,
    input wire logic tx_char_done,
    input wire logic tx_char_nak,
    input wire logic half_etu_tick,
    input wire logic framing_evt,
    input wire logic early_answer_evt,
    input wire logic [2:0] timeout_evt,
    output logic tx_start,
    output logic [7:0] tx_data,
    output logic irq_n
);
    logic ack_r;
    logic acc;
    logic [7:0] fcr_r;
    logic [7:0] ctrl_r;
    logic [2:0] aux_sync_r;
    logic aux_r;
    logic [7:0] fifo_mem_r [0:7];
    logic [3:0] fifo_cnt_r;
    logic [3:0] depth;
    logic fifo_full;
    logic fifo_push;
    logic fifo_pop;
    logic tbe_r;
    logic [`CUF_TBE_DLY-1:0] tbe_dly_r;
    logic txmode_q_r;
    logic run_q_r;
    logic [2:0] err_cnt_r;
    logic pe_r;
    logic ovr_r;
    logic fer_r;
    logic ea_r;
    logic [2:0] to_r;
    logic [6:0] clr_mask_r;
    logic [7:0] clr_cnt_r;
    logic clr_fire;
    logic rx_pe_evt;
    logic tx_pe_evt;
    logic tx_retry_evt;
    logic wr_tx;
    logic rd_rx;
    logic rd_st;
    cuf_pkg::cuf_tx_state_t tx_st_r;
    logic [5:0] half_r;
    logic nak_seen_r;
    logic lct_char_r;
    logic [7:0] uart_status_register;
    logic [7:0] mixed_status_register;

    // avalon slave: one wait state, effects on the accepting edge
    assign waitrequest = (read | write) & ~ack_r;
    assign acc = (read | write) & ack_r;
    assign wr_tx = acc & write & (address == `CUF_IDX_RXHOLD);
    assign rd_rx = acc & read & (address == `CUF_IDX_RXHOLD);
    assign rd_st = acc & read & (address == `CUF_IDX_STATUS);

    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (read | write) & ~ack_r;
        end
    end

    assign mixed_status_register = {1'b0, (fifo_cnt_r == 4'h0), 1'b0, ~|tbe_dly_r, 2'b00, aux_r, tbe_r};
    assign uart_status_register = {to_r[2], to_r[1], to_r[0], ea_r, pe_r, ovr_r, fer_r, tbe_r};

    always_ff @(posedge clk) begin
        if (rst) begin
            readdata <= 32'h0000_0000;
        end else if (read & ~ack_r) begin
            case (address)
                `CUF_IDX_MIXED: readdata <= {24'h000000, mixed_status_register};
                `CUF_IDX_RXHOLD: readdata <= {24'h000000, fifo_mem_r[0]};
                `CUF_IDX_STATUS: readdata <= {24'h000000, uart_status_register};
                `CUF_IDX_CTRL: readdata <= {24'h000000, ctrl_r};
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fcr_r <= `CUF_FCR_RST;
            ctrl_r <= `CUF_CTRL_RST;
        end else if (acc & write) begin
            if (address == `CUF_IDX_MIXED) begin
                fcr_r <= {1'b0, writedata[`CUF_PEC_HI:`CUF_PEC_LO], 1'b0,
                          writedata[`CUF_FL_HI:`CUF_FL_LO]};
            end
            if (address == `CUF_IDX_CTRL) begin
                ctrl_r <= writedata[7:0];
            end
        end
    end

    // aux pin: three stages, accepted when the last two agree
    always_ff @(posedge clk) begin
        if (rst) begin
            aux_sync_r <= 3'b000;
            aux_r <= 1'b0;
        end else begin
            aux_sync_r <= {aux_sync_r[1:0], aux_irq_input};
            if (aux_sync_r[1] == aux_sync_r[2]) begin
                aux_r <= aux_sync_r[2];
            end
        end
    end

    // receive fifo, read port always at entry 0
    assign depth = {1'b0, fcr_r[`CUF_FL_HI:`CUF_FL_LO]} + 4'h1;
    assign fifo_full = (fifo_cnt_r >= depth);
    assign fifo_pop = rd_rx & (fifo_cnt_r != 4'h0);
    assign fifo_push = rx_char_valid & ~fifo_full &
                       ~(rx_parity_bad & ~ctrl_r[`CUF_CTRL_T1]);

    always_ff @(posedge clk) begin
        if (rst | ~ctrl_r[`CUF_CTRL_RUN]) begin
            fifo_cnt_r <= 4'h0;
        end else begin
            fifo_cnt_r <= fifo_cnt_r + {3'b000, fifo_push} - {3'b000, fifo_pop};
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < 8; i++) begin
            if (rst) begin
                fifo_mem_r[i] <= 8'h00;
            end else if (fifo_push & (4'(i) == fifo_cnt_r - {3'b000, fifo_pop})) begin
                fifo_mem_r[i] <= rx_char_data;
            end else if (fifo_pop) begin
                fifo_mem_r[i] <= (i < 7) ? fifo_mem_r[(i < 7) ? i + 1 : i] : 8'h00;
            end
        end
    end

    // shared tx-empty/rx-full flag
    always_ff @(posedge clk) begin
        if (rst) begin
            tbe_dly_r <= '0;
            txmode_q_r <= 1'b0;
            run_q_r <= 1'b0;
        end else begin
            tbe_dly_r <= {tbe_dly_r[`CUF_TBE_DLY-2:0], wr_tx | fifo_pop};
            txmode_q_r <= ctrl_r[`CUF_CTRL_TXMODE];
            run_q_r <= ctrl_r[`CUF_CTRL_RUN];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tbe_r <= 1'b0;
        end else if ((ctrl_r[`CUF_CTRL_TXMODE] & ~txmode_q_r) |
                     (tx_char_done & ~lct_char_r) |
                     (fifo_push & (fifo_cnt_r + 4'h1 == depth))) begin
            tbe_r <= 1'b1;
        end else if ((~ctrl_r[`CUF_CTRL_RUN] & run_q_r) |
                     (~ctrl_r[`CUF_CTRL_TXMODE] & txmode_q_r) |
                     tbe_dly_r[`CUF_TBE_DLY-1]) begin
            tbe_r <= 1'b0;
        end
    end

    // parity error counting, shared by reception and transmission
    assign rx_pe_evt = rx_char_valid & rx_parity_bad &
                       (ctrl_r[`CUF_CTRL_T1] |
                        (err_cnt_r == fcr_r[`CUF_PEC_HI:`CUF_PEC_LO]));
    assign tx_pe_evt = tx_char_nak & ~ctrl_r[`CUF_CTRL_T1] &
                       (err_cnt_r == fcr_r[`CUF_PEC_HI:`CUF_PEC_LO]);
    assign tx_retry_evt = tx_char_nak & ~ctrl_r[`CUF_CTRL_T1] & ~tx_pe_evt;

    always_ff @(posedge clk) begin
        if (rst | ~ctrl_r[`CUF_CTRL_RUN]) begin
            err_cnt_r <= 3'b000;
        end else if (rx_pe_evt | tx_pe_evt | wr_tx) begin
            err_cnt_r <= 3'b000;
        end else if (rx_char_valid & ~ctrl_r[`CUF_CTRL_T1]) begin
            err_cnt_r <= rx_parity_bad ? err_cnt_r + 3'b001 : 3'b000;
        end else if (tx_retry_evt) begin
            err_cnt_r <= err_cnt_r + 3'b001;
        end
    end

    // read-to-clear: flags seen at a status read drop 2 us later
    assign clr_fire = (clr_cnt_r == 8'h01);

    always_ff @(posedge clk) begin
        if (rst) begin
            clr_cnt_r <= 8'h00;
            clr_mask_r <= 7'h00;
        end else if (rd_st) begin
            clr_cnt_r <= 8'(`CUF_CLR_CYC);
            clr_mask_r <= uart_status_register[7:1];
        end else if (clr_cnt_r != 8'h00) begin
            clr_cnt_r <= clr_cnt_r - 8'h01;
        end
    end

    // events set, timed clear drops only flags snapshotted; set wins
    always_ff @(posedge clk) begin
        if (rst) begin
            pe_r <= 1'b0;
            ovr_r <= 1'b0;
            fer_r <= 1'b0;
            ea_r <= 1'b0;
            to_r <= 3'b000;
        end else begin
            pe_r <= (rx_pe_evt | tx_pe_evt) |
                    (pe_r & ~(clr_fire & clr_mask_r[2]));
            ovr_r <= (rx_char_valid & fifo_full) | (ovr_r & ~(clr_fire & clr_mask_r[1]));
            fer_r <= framing_evt | (fer_r & ~(clr_fire & clr_mask_r[0]));
            ea_r <= early_answer_evt | (ea_r & ~(clr_fire & clr_mask_r[3]));
            to_r <= timeout_evt | (to_r & ~({3{clr_fire}} & clr_mask_r[6:4]));
        end
    end

    assign irq_n = ~((|uart_status_register[7:1]) | (tbe_r & ~ctrl_r[`CUF_CTRL_MASK]));

    // transmit sequencing with half-etu timing from character start
    always_ff @(posedge clk) begin
        if (rst | tx_start) begin
            half_r <= 6'h00;
        end else if (half_etu_tick & (half_r != `CUF_HALF_MAX)) begin
            half_r <= half_r + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst | ~ctrl_r[`CUF_CTRL_RUN]) begin
            tx_st_r <= cuf_pkg::CUF_TX_IDLE;
            tx_start <= 1'b0;
            tx_data <= 8'h00;
            nak_seen_r <= 1'b0;
            lct_char_r <= 1'b0;
        end else begin
            tx_start <= 1'b0;
            case (tx_st_r)
                cuf_pkg::CUF_TX_IDLE: begin
                    if (wr_tx) begin
                        tx_data <= writedata[7:0];
                        lct_char_r <= ctrl_r[`CUF_CTRL_LCT];
                        tx_st_r <= cuf_pkg::CUF_TX_MANUAL;
                    end
                end
                cuf_pkg::CUF_TX_MANUAL: begin
                    if (~nak_seen_r | (half_r >= `CUF_MANUAL_HALF)) begin
                        tx_start <= 1'b1;
                        nak_seen_r <= 1'b0;
                        tx_st_r <= cuf_pkg::CUF_TX_SEND;
                    end
                end
                cuf_pkg::CUF_TX_SEND: begin
                    if (tx_retry_evt) begin
                        tx_st_r <= cuf_pkg::CUF_TX_RETRY;
                    end else if (tx_char_nak) begin
                        nak_seen_r <= 1'b1;
                        tx_st_r <= cuf_pkg::CUF_TX_IDLE;
                    end else if (tx_char_done) begin
                        tx_st_r <= cuf_pkg::CUF_TX_IDLE;
                    end
                end
                cuf_pkg::CUF_TX_RETRY: begin
                    if (half_r >= `CUF_RETX_HALF) begin
                        tx_start <= 1'b1;
                        tx_st_r <= cuf_pkg::CUF_TX_SEND;
                    end
                end
                default: tx_st_r <= cuf_pkg::CUF_TX_IDLE;
            endcase
        end
    end
endmodule

// file: bench/cuf_core_chk.sv
`timescale 1ns/10ps
module cuf_core_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic aux_irq_input,
    input wire logic framing_evt,
    input wire logic early_answer_evt,
    input wire logic [2:0] timeout_evt,
    input wire logic tx_char_nak,
    input wire logic half_etu_tick,
    input wire logic tx_start,
    input wire logic [7:0] tx_data,
    input wire logic irq_n
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    logic [3:0] aux_age_r;
    logic [6:0] half_cnt_r;
    logic [2:0] wr_age_r;
    logic nak_seen_r;
    // ages since aux change, since tx start (half etu) and since tx write
    always_ff @(posedge clk) begin
        aux_age_r <= (rst || $changed(aux_irq_input)) ? 4'h0 : aux_age_r + {3'h0, &aux_age_r == 1'h0};
        half_cnt_r <= (rst || tx_start) ? 7'h00
            : half_cnt_r + {6'h00, half_etu_tick && half_cnt_r != 7'h7F};
        wr_age_r <= (rst || (write && !waitrequest && address == 6'h0D)) ? 3'h0
            : wr_age_r + {2'h0, &wr_age_r == 1'h0};
        nak_seen_r <= !rst && !tx_start && (nak_seen_r || tx_char_nak);
    end
    sequence req_wait;
        (read || write) && waitrequest;
    endsequence
    sequence rd_done(a);
        read && !waitrequest && address == a;
    endsequence
    wait_one_a: assert property (req_wait |=> !waitrequest)
        else $error("wait too long");
    upper_zero_a: assert property (read && !waitrequest |-> readdata[31:8] == 24'h00_0000)
        else $error("upper data set");
    unmapped_zero_a: assert property (rd_done(6'h3F) |-> readdata == 32'h0000_0000)
        else $error("unmapped data");
    aux_mirror_a: assert property (
        rd_done(6'h0C) ##0 aux_age_r >= 4'h8 |-> readdata[1] == aux_irq_input)
        else $error("aux bit wrong");
    evt_irq_a: assert property (
        framing_evt || early_answer_evt || timeout_evt != 3'h0 |=> !irq_n)
        else $error("irq missing");
    tx_pulse_a: assert property (tx_start |=> !tx_start)
        else $error("tx start long");
    retx_space_a: assert property (tx_start && nak_seen_r |-> half_cnt_r >= 7'h1B)
        else $error("resend early");
    tx_hold_a: assert property ($changed(tx_data) |-> wr_age_r <= 3'h3)
        else $error("tx data moved");
endmodule

// file: bench/cuf_card.sv
`timescale 1ns/10ps
module cuf_card (
    input wire logic clk,
    input wire logic rst,
    input wire logic tx_start,
    output logic half_etu_tick,
    output logic tx_char_done,
    output logic tx_char_nak,
    output logic rx_char_valid,
    output logic [7:0] rx_char_data,
    output logic rx_parity_bad
);
    logic [1:0] div_r;
    logic [5:0] etu_r;
    logic busy_r;
    logic ans;
    int naks_left;
    initial begin
        {div_r, etu_r, busy_r, half_etu_tick, tx_char_done, tx_char_nak, rx_char_valid} = '0;
        {rx_char_data, rx_parity_bad} = '0;
        naks_left = 0;
    end
    // half etu of 4 clocks; a char is answered at its 23rd half etu, nak while naks pending
    assign ans = busy_r && half_etu_tick && etu_r == 6'h16;
    always @(posedge clk) begin
        div_r <= div_r + 2'h1;
        half_etu_tick <= div_r == 2'h3;
        tx_char_done <= ans && naks_left == 0;
        tx_char_nak <= ans && naks_left != 0;
        if (tx_start || rst) begin
            busy_r <= tx_start;
            etu_r <= 6'h00;
        end else if (busy_r && half_etu_tick) begin
            etu_r <= etu_r + 6'h01;
            busy_r <= !ans;
            if (ans && naks_left != 0) naks_left <= naks_left - 1;
        end
    end
    // data lines show the inverse once the char is gone
    task send(input logic [7:0] d, input logic bad);
        @(posedge clk);
        {rx_char_valid, rx_char_data, rx_parity_bad} <= {1'h1, d, bad};
        @(posedge clk);
        {rx_char_valid, rx_char_data, rx_parity_bad} <= {1'h0, ~d, ~bad};
        repeat (20) @(posedge clk);
    endtask
endmodule

// file: bench/card_uart_fifo_status_tb.sv
`timescale 1ns/10ps
`include "cuf_regs.svh"
module card_uart_fifo_status_tb;
    logic clk, rst, read, write, waitrequest, aux_irq_input, rx_char_valid, rx_parity_bad;
    logic tx_char_done, tx_char_nak, half_etu_tick, framing_evt, early_answer_evt, tx_start;
    logic irq_n;
    logic [5:0] address;
    logic [31:0] writedata, readdata, q;
    logic [7:0] rx_char_data, tx_data;
    logic [2:0] timeout_evt;
    int err_count, compares, n_tx, n0;
    cuf_core u_dut (.clk, .rst, .address, .read, .write, .writedata, .readdata, .waitrequest,
        .aux_irq_input, .rx_char_valid, .rx_char_data, .rx_parity_bad, .tx_char_done,
        .tx_char_nak, .half_etu_tick, .framing_evt, .early_answer_evt, .timeout_evt,
        .tx_start, .tx_data, .irq_n);
    cuf_card u_card (.clk, .rst, .tx_start, .half_etu_tick, .tx_char_done, .tx_char_nak,
        .rx_char_valid, .rx_char_data, .rx_parity_bad);
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (tx_start === 1'h1) n_tx <= n_tx + 1;
    end
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
        {address, writedata, write, read} <= {a, 24'h00_0000, d, w, ~w};
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'h0);
        q = readdata;
        {write, read} <= 2'h0;
        @(posedge clk);
    endtask
    // poll control-ready before the next holding-register access
    task wait_control_ready_flag();
        do begin
            bus(1'h0, `CUF_IDX_MIXED, 8'h00);
        end while (q[4] !== 1'h1);
    endtask
    task rd(input logic [5:0] a, input logic [31:0] exp, input string what);
        bus(1'h0, a, 8'h00);
        chk(what, q, exp);
    endtask
    task t_regs();
        rd(6'h3F, 32'h0, "unmapped");
        bus(1'h1, `CUF_IDX_MIXED, 8'hFF);
        rd(`CUF_IDX_MIXED, 32'h50, "mixed");
        aux_irq_input <= 1'h1;
        repeat (8) @(posedge clk);
        rd(`CUF_IDX_MIXED, 32'h52, "aux");
        aux_irq_input <= 1'h0;
        for (int i = 0; i < 5; i++) begin
            {timeout_evt, early_answer_evt, framing_evt} <= 5'h01 << i;
            @(posedge clk);
            {timeout_evt, early_answer_evt, framing_evt} <= 5'h00;
            @(posedge clk);
            chk("irq set", irq_n, 1'h0);
            rd(`CUF_IDX_STATUS, i ? 32'h08 << i : 32'h02, "status");
            repeat (`CUF_CLR_CYC + 4) @(posedge clk);
            chk("irq clr", irq_n, 1'h1);
        end
        $display("regs end");
    endtask
    task t_rx();
        bus(1'h1, `CUF_IDX_CTRL, 8'h01);
        bus(1'h1, `CUF_IDX_MIXED, 8'h12);
        u_card.send(8'hA1, 1'h0);
        u_card.send(8'hA2, 1'h1);
        u_card.send(8'hA3, 1'h0);
        u_card.send(8'hA4, 1'h1);
        chk("no pe", irq_n, 1'h1);
        u_card.send(8'hA5, 1'h0);
        chk("full irq", irq_n, 1'h0);
        bus(1'h1, `CUF_IDX_CTRL, 8'h11);
        chk("masked", irq_n, 1'h1);
        bus(1'h1, `CUF_IDX_CTRL, 8'h01);
        chk("unmasked", irq_n, 1'h0);
        rd(`CUF_IDX_MIXED, 32'h11, "full");
        rd(`CUF_IDX_RXHOLD, 32'hA1, "pop");
        repeat (3) @(posedge clk);
        rd(`CUF_IDX_MIXED, 32'h10, "rbf clr");
        wait_control_ready_flag();
        rd(`CUF_IDX_RXHOLD, 32'hA3, "pop");
        u_card.send(8'hA6, 1'h1);
        u_card.send(8'hA7, 1'h1);
        repeat (250) @(posedge clk);
        chk("pe held", irq_n, 1'h0);
        rd(`CUF_IDX_STATUS, 32'h08, "pe");
        repeat (`CUF_CLR_CYC + 4) @(posedge clk);
        chk("pe clr", irq_n, 1'h1);
        bus(1'h1, `CUF_IDX_CTRL, 8'h05);
        bus(1'h1, `CUF_IDX_MIXED, 8'h77);
        u_card.send(8'hB1, 1'h1);
        chk("t1 pe", irq_n, 1'h0);
        rd(`CUF_IDX_RXHOLD, 32'hA5, "pop");
        rd(`CUF_IDX_RXHOLD, 32'hB1, "t1 kept");
        rd(`CUF_IDX_STATUS, 32'h08, "t1 status");
        $display("rx end");
    endtask
    task t_tx();
        bus(1'h1, `CUF_IDX_CTRL, 8'h03);
        rd(`CUF_IDX_MIXED, 32'h51, "tbe on tx");
        bus(1'h1, `CUF_IDX_MIXED, 8'h10);
        u_card.naks_left <= 1;
        n0 = n_tx;
        bus(1'h1, `CUF_IDX_RXHOLD, 8'h41);
        repeat (300) @(posedge clk);
        chk("resends", n_tx - n0, 32'h2);
        chk("tx data", tx_data, 32'h41);
        rd(`CUF_IDX_STATUS, 32'h01, "tbe done");
        bus(1'h1, `CUF_IDX_MIXED, 8'h00);
        u_card.naks_left <= 1;
        bus(1'h1, `CUF_IDX_RXHOLD, 8'h42);
        for (int i = 0; i < 200 && tx_char_nak !== 1'h1; i++) @(posedge clk);
        chk("nak seen", tx_char_nak, 1'h1);
        wait_control_ready_flag();
        bus(1'h1, `CUF_IDX_RXHOLD, 8'h42);
        repeat (300) @(posedge clk);
        chk("manual", n_tx - n0, 32'h4);
        rd(`CUF_IDX_STATUS, 32'h09, "pe first");
        bus(1'h1, `CUF_IDX_CTRL, 8'h01);
        rd(`CUF_IDX_MIXED, 32'h50, "tx to rx");
        bus(1'h1, `CUF_IDX_CTRL, 8'h0B);
        bus(1'h1, `CUF_IDX_RXHOLD, 8'h43);
        repeat (150) @(posedge clk);
        rd(`CUF_IDX_MIXED, 32'h50, "last char");
        $display("tx end");
    endtask
    task results();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        {rst, read, write, address, writedata, aux_irq_input} = {3'h4, 6'h00, 32'h0, 1'h0};
        {framing_evt, early_answer_evt, timeout_evt, n_tx} = '0;
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        t_regs();
        t_rx();
        t_tx();
        results();
    end
    initial begin
        #200000;
        err_count++;
        results();
    end
endmodule
bind cuf_core cuf_core_chk u_chk (.clk, .rst, .address, .read, .write, .readdata, .waitrequest,
    .aux_irq_input, .framing_evt, .early_answer_evt, .timeout_evt, .tx_char_nak,
    .half_etu_tick, .tx_start, .tx_data, .irq_n);
